// ### core/aepr_flags.sv
// Almost-empty and packet-ready flag logic for an eight-queue flow-control store.
// Assumes write and read controllers synchronous to clk and an APB master on the same clock.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - equal widths shared queue: offset plus two
// - wide in, narrow out: offset plus one
// - narrow in: offset plus two, scaled
// - write-only selection: bus uses offset plus one
// - default offset eight or 128 by strap
// - flag falls two cycles after read
// - flag rises one cycle after write
// - bus bit: two after read, one after write
// - read queue switch may add one cycle
// - packet ready edges follow the read clock
// - end marker after start marker: packet ready
// - ready shows two cycles after end write
// - last start marker read clears ready
// - not ready shows three cycles after read
// - bus ready bit falls like discrete flag
// - bus ready bit rises when packets gone
// - packet mode: no reads before complete packet
module aepr_flags (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic default_offset_select,
    input wire logic packet_mode_select,
    input wire logic wr_en,
    input wire logic [2:0] wr_queue,
    input wire logic write_start_of_packet_marker,
    input wire logic write_end_of_packet_marker,
    output logic wr_accept,
    input wire logic rd_en,
    input wire logic [2:0] rd_queue,
    input wire logic read_start_of_packet_marker,
    output logic rd_accept,
    output logic almost_empty_flag_n,
    output logic packet_ready_flag_n,
    output logic [7:0] almost_empty_status_bus_n,
    output logic [7:0] packet_ready_status_bus_n
);
    // Registered state and its next value.
    aepr_pkg::aepr_top_s s_r;
    aepr_pkg::aepr_top_s s_nxt;
    // Per-queue results of the trackers.
    logic [7:0] can_read_q;
    logic [7:0] can_write_q;
    logic [7:0] has_packet_q;
    logic [7:0] ae_flag_q;
    logic [7:0] ae_bus_q;
    logic [7:0] pr_flag_q;
    logic [7:0] pr_bus_q;
    // Units moved by one write word and one read word.
    logic [2:0] wr_units;
    logic [2:0] rd_units;
    // Thresholds in 9-bit units for the discrete flag and the two bus cases.
    logic [17:0] thr_flag;
    logic [17:0] thr_bus_shared;
    logic [17:0] thr_bus_single;
    // Read port is changing queues this cycle.
    logic rd_switch;
    // APB setup and write-access phases this cycle, and the running state.
    logic apb_setup;
    logic apb_write;
    logic running;

    // Map a width code to the number of 9-bit units in one word.
    function automatic logic [2:0] width_units(input logic [1:0] code);
        logic [2:0] u;
        u = aepr_pkg::UNITS_X36;
        if (code == aepr_pkg::WIDTH_X18) begin
            u = aepr_pkg::UNITS_X18;
        end else if (code == aepr_pkg::WIDTH_X9) begin
            u = aepr_pkg::UNITS_X9;
        end
        return u;
    endfunction : width_units

    // Thresholds: a 36-bit word is four units, so offset plus margin times four
    // equals the printed write counts scaled by two or four for narrow input.
    always_comb begin
        wr_units = width_units(s_r.in_w);
        rd_units = width_units(s_r.out_w);
        if ((s_r.in_w == aepr_pkg::WIDTH_X36) && (s_r.out_w != aepr_pkg::WIDTH_X36)) begin
            // Wide writes into narrow reads need one word fewer.
            thr_flag = {s_r.offset + aepr_pkg::MARGIN_SINGLE, 2'b00};
            thr_bus_shared = thr_flag;
        end else begin
            // Shared queue with equal widths or narrow input counts the word held at the output.
            thr_flag = {s_r.offset + aepr_pkg::MARGIN_SHARED, 2'b00};
            thr_bus_shared = thr_flag;
        end
        // Filled with only the write port selected, the bus bit needs offset plus one words for every width pair.
        thr_bus_single = {s_r.offset + aepr_pkg::MARGIN_SINGLE, 2'b00};
    end

    // Port handshakes; in packet mode a read waits for a complete packet.
    always_comb begin
        running = s_r.cfg == aepr_pkg::AEPR_CFG_RUN;
        rd_switch = rd_queue != s_r.last_rq;
        wr_accept = running && wr_en && can_write_q[wr_queue];
        rd_accept = running && rd_en && can_read_q[rd_queue]
                    && (!s_r.pkt_mode || has_packet_q[rd_queue]);
        apb_setup = psel && !penable;
        apb_write = psel && penable && pwrite;
    end

    // One tracker per queue; the trackers hold every per-queue count.
    genvar gq;
    generate
        for (gq = 0; gq < 8; gq++) begin : g_queue
            aepr_queue_track u_track (
                .clk(clk),
                .reset_n(reset_n),
                .wr_hit(wr_accept && (wr_queue == 3'(gq))),
                .wr_units(wr_units),
                .wr_sop(write_start_of_packet_marker),
                .wr_eop(write_end_of_packet_marker),
                .rd_hit(rd_accept && (rd_queue == 3'(gq))),
                .rd_units(rd_units),
                .rd_sop(read_start_of_packet_marker),
                .rd_selected(rd_queue == 3'(gq)),
                .bus_hold(rd_switch),
                .thr_flag(thr_flag),
                .thr_bus_shared(thr_bus_shared),
                .thr_bus_single(thr_bus_single),
                .can_read(can_read_q[gq]),
                .can_write(can_write_q[gq]),
                .has_packet(has_packet_q[gq]),
                .ae_flag_lvl(ae_flag_q[gq]),
                .ae_bus_lvl(ae_bus_q[gq]),
                .pr_flag_lvl(pr_flag_q[gq]),
                .pr_bus_lvl(pr_bus_q[gq])
            );
        end
    endgenerate

    // Next-state logic: strap capture, register writes and read data.
    always_comb begin
        s_nxt = s_r;
        s_nxt.last_rq = rd_queue;
        case (s_r.cfg)
            aepr_pkg::AEPR_CFG_WAIT: begin
                // The first clocked cycle after reset release catches the straps.
                s_nxt.pkt_mode = packet_mode_select;
                s_nxt.df_strap = default_offset_select;
                s_nxt.offset = default_offset_select ? aepr_pkg::OFFSET_DEFAULT_HIGH
                                                     : aepr_pkg::OFFSET_DEFAULT_LOW;
                s_nxt.cfg = aepr_pkg::AEPR_CFG_RUN;
            end
            aepr_pkg::AEPR_CFG_RUN: begin
                // Software may change the widths and the offset once running.
                if (apb_write && (paddr == aepr_pkg::ADDR_CTRL)) begin
                    s_nxt.in_w = pwdata[aepr_pkg::CTRL_IN_LSB +: 2];
                    s_nxt.out_w = pwdata[aepr_pkg::CTRL_OUT_LSB +: 2];
                end
                if (apb_write && (paddr == aepr_pkg::ADDR_OFFSET)) begin
                    s_nxt.offset = pwdata[15:0];
                end
            end
            default: begin
                // An illegal code restarts the capture.
                s_nxt.cfg = aepr_pkg::AEPR_CFG_WAIT;
            end
        endcase
        if (apb_setup) begin
            // Read data is built in the setup cycle so the access phase needs no wait.
            s_nxt.prdata = 32'h00000000;
            s_nxt.pslverr = 1'b0;
            case (paddr)
                aepr_pkg::ADDR_CTRL: begin
                    s_nxt.prdata[aepr_pkg::CTRL_IN_LSB +: 2] = s_r.in_w;
                    s_nxt.prdata[aepr_pkg::CTRL_OUT_LSB +: 2] = s_r.out_w;
                    s_nxt.prdata[aepr_pkg::CTRL_PKT_BIT] = s_r.pkt_mode;
                    s_nxt.prdata[aepr_pkg::CTRL_DF_BIT] = s_r.df_strap;
                end
                aepr_pkg::ADDR_OFFSET: begin
                    s_nxt.prdata[15:0] = s_r.offset;
                end
                aepr_pkg::ADDR_STATUS: begin
                    s_nxt.prdata[aepr_pkg::STAT_AE_LSB +: 8] = almost_empty_status_bus_n;
                    s_nxt.prdata[aepr_pkg::STAT_PR_LSB +: 8] = packet_ready_status_bus_n;
                    s_nxt.prdata[aepr_pkg::STAT_AEF_BIT] = almost_empty_flag_n;
                    s_nxt.prdata[aepr_pkg::STAT_PRF_BIT] = packet_ready_flag_n;
                end
                default: begin
                    // Unmapped addresses read zero and report an error.
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
    end

    // State register with constant reset values.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r.cfg <= aepr_pkg::AEPR_CFG_WAIT;
            s_r.pkt_mode <= 1'b0;
            s_r.df_strap <= 1'b0;
            s_r.in_w <= aepr_pkg::CTRL_WIDTH_RESET;
            s_r.out_w <= aepr_pkg::CTRL_WIDTH_RESET;
            s_r.offset <= aepr_pkg::OFFSET_DEFAULT_LOW;
            s_r.last_rq <= 3'h0;
            s_r.prdata <= 32'h00000000;
            s_r.pslverr <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; packet ready is held inactive in word mode.
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = s_r.pslverr && psel && penable;
    assign almost_empty_flag_n = ae_flag_q[rd_queue];
    assign almost_empty_status_bus_n = ae_bus_q;
    assign packet_ready_flag_n = !(s_r.pkt_mode && pr_flag_q[rd_queue]);
    assign packet_ready_status_bus_n = s_r.pkt_mode ? ~pr_bus_q : 8'hff;

    // A strap-driven default offset lands in the first cycle after reset.
    dflt_offset_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(s_r.cfg) == aepr_pkg::AEPR_CFG_WAIT && s_r.cfg == aepr_pkg::AEPR_CFG_RUN)
        |-> s_r.offset == ($past(default_offset_select) ? aepr_pkg::OFFSET_DEFAULT_HIGH
        : aepr_pkg::OFFSET_DEFAULT_LOW))
        else $error("default offset wrong");
    // Packet mode never lets a read through without a complete packet.
    pkt_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_r.pkt_mode && rd_en && !has_packet_q[rd_queue]) |-> !rd_accept)
        else $error("read accepted without packet");
    // Wide writes into narrow reads use offset plus one words.
    thr_narrow_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_r.in_w == 2'h0 && s_r.out_w != 2'h0) |-> thr_flag == 18'(({2'b00, s_r.offset} + 18'h1) * 4))
        else $error("narrow-read threshold wrong");
    // Equal or narrow input into a 36-bit read port uses offset plus two words of the read width.
    thr_shared_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_r.out_w == 2'h0) |-> thr_flag == 18'(({2'b00, s_r.offset} + 18'h2) * 4))
        else $error("shared threshold wrong");
    // In word mode the packet-ready outputs stay inactive.
    word_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        !s_r.pkt_mode |-> packet_ready_flag_n && (packet_ready_status_bus_n == 8'hff))
        else $error("packet ready active in word mode");
endmodule : aepr_flags
`default_nettype wire

// ### core/aepr_pkg.sv
// Shared constants and state types of the almost-empty and packet-ready flag block.
// Assumes a single 200 MHz clock and an APB register port in the enclosing design.
package aepr_pkg;

    // Number of queues tracked, equal to the width of one status word.
    localparam int unsigned NUM_QUEUES = 8;
    // Width of a queue index.
    localparam int unsigned QIDX_W = 3;
    // Occupancy is counted in 9-bit units so that every width ratio shares one counter.
    localparam int unsigned UNITS_W = 18;
    // Width of the complete-packet counter.
    localparam int unsigned PKTS_W = 16;
    // Width of the almost-empty offset.
    localparam int unsigned OFFSET_W = 16;

    // Default almost-empty offsets chosen by the default-offset select input.
    localparam logic [15:0] OFFSET_DEFAULT_LOW = 16'h0008;
    localparam logic [15:0] OFFSET_DEFAULT_HIGH = 16'h0080;
    // Margin added to the offset when both ports share the queue, or only one applies.
    localparam logic [15:0] MARGIN_SHARED = 16'h0002;
    localparam logic [15:0] MARGIN_SINGLE = 16'h0001;
    // Units taken by one word of each width code.
    localparam logic [2:0] UNITS_X36 = 3'h4;
    localparam logic [2:0] UNITS_X18 = 3'h2;
    localparam logic [2:0] UNITS_X9 = 3'h1;
    // Largest occupancy kept, leaving room for one more 36-bit word.
    localparam logic [17:0] UNITS_LIMIT = 18'h3fffb;

    // Port width codes.
    localparam logic [1:0] WIDTH_X36 = 2'h0;
    localparam logic [1:0] WIDTH_X18 = 2'h1;
    localparam logic [1:0] WIDTH_X9 = 2'h2;

    // APB byte addresses of the registers.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OFFSET = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // Field positions inside the control register.
    localparam int unsigned CTRL_IN_LSB = 0;
    localparam int unsigned CTRL_OUT_LSB = 2;
    localparam int unsigned CTRL_PKT_BIT = 4;
    localparam int unsigned CTRL_DF_BIT = 5;
    // Field positions inside the status register.
    localparam int unsigned STAT_AE_LSB = 0;
    localparam int unsigned STAT_PR_LSB = 8;
    localparam int unsigned STAT_AEF_BIT = 16;
    localparam int unsigned STAT_PRF_BIT = 17;
    // Reset values of the software-written widths.
    localparam logic [1:0] CTRL_WIDTH_RESET = 2'h0;

    // Configuration phase: one cycle to catch the straps, then running.
    typedef enum logic [1:0] {
        AEPR_CFG_WAIT = 2'b01,
        AEPR_CFG_RUN = 2'b10
    } aepr_cfg_e;

    // State of one queue tracker.
    typedef struct packed {
        logic [17:0] units;
        logic [15:0] pkts;
        logic sop_open;
        logic wr_only;
        logic aef_a;
        logic aef_b;
        logic aef_lvl;
        logic aeb_a;
        logic aeb_b;
        logic aeb_lvl;
        logic pr_p1;
        logic pr_p2;
        logic pr_p3;
        logic pr_lvl;
        logic prb_lvl;
    } aepr_queue_s;

    // State of the top-level flag block.
    typedef struct packed {
        aepr_cfg_e cfg;
        logic pkt_mode;
        logic df_strap;
        logic [1:0] in_w;
        logic [1:0] out_w;
        logic [15:0] offset;
        logic [2:0] last_rq;
        logic [31:0] prdata;
        logic pslverr;
    } aepr_top_s;

endpackage : aepr_pkg

// ### core/aepr_queue_track.sv
// Per-queue occupancy and complete-packet tracker with flag pipelines.
// Assumes the parent gates reads and writes so the occupancy counter never wraps.
`timescale 1ns/1ps
`default_nettype none
module aepr_queue_track (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_hit,
    input wire logic [2:0] wr_units,
    input wire logic wr_sop,
    input wire logic wr_eop,
    input wire logic rd_hit,
    input wire logic [2:0] rd_units,
    input wire logic rd_sop,
    input wire logic rd_selected,
    input wire logic bus_hold,
    input wire logic [17:0] thr_flag,
    input wire logic [17:0] thr_bus_shared,
    input wire logic [17:0] thr_bus_single,
    output logic can_read,
    output logic can_write,
    output logic has_packet,
    output logic ae_flag_lvl,
    output logic ae_bus_lvl,
    output logic pr_flag_lvl,
    output logic pr_bus_lvl
);
    // Registered state and its next value.
    aepr_pkg::aepr_queue_s q_r;
    aepr_pkg::aepr_queue_s q_nxt;
    // A write that closes a packet opened earlier or by the same word.
    logic eop_complete;

    // Next-state logic: counters first, then flag pipelines fed from the new counts.
    always_comb begin
        q_nxt = q_r;
        eop_complete = wr_hit && wr_eop && (q_r.sop_open || wr_sop);
        // Occupancy in 9-bit units, so every width ratio uses the same threshold scale.
        q_nxt.units = q_r.units + (wr_hit ? 18'(wr_units) : 18'h00000)
                      - (rd_hit ? 18'(rd_units) : 18'h00000);
        // Complete packets: a closing end marker adds one, a read start marker removes one.
        q_nxt.pkts = q_r.pkts + (eop_complete ? 16'h0001 : 16'h0000)
                     - ((rd_hit && rd_sop) ? 16'h0001 : 16'h0000);
        if (wr_hit) begin
            // An end marker closes the packet, a start marker opens one.
            q_nxt.sop_open = wr_eop ? 1'b0 : (wr_sop | q_r.sop_open);
        end
        if (wr_hit && (q_r.units == 18'h00000)) begin
            // The first word decides whether the read side had the queue selected.
            q_nxt.wr_only = !rd_selected;
        end
        // Discrete flag: rises one cycle after a write, falls two cycles after a read.
        q_nxt.aef_a = q_nxt.units >= thr_flag;
        q_nxt.aef_b = q_r.aef_a;
        q_nxt.aef_lvl = q_r.aef_a | q_r.aef_b;
        // Status-bus bit uses its own threshold and may stall during a read queue switch.
        q_nxt.aeb_a = q_nxt.units >= (q_nxt.wr_only ? thr_bus_single : thr_bus_shared);
        q_nxt.aeb_b = q_r.aeb_a;
        if (!bus_hold) begin
            q_nxt.aeb_lvl = q_r.aeb_a | q_r.aeb_b;
        end
        // Packet ready: ready two cycles after the write, not ready three after the read.
        q_nxt.pr_p1 = q_nxt.pkts != 16'h0000;
        q_nxt.pr_p2 = q_r.pr_p1;
        q_nxt.pr_p3 = q_r.pr_p2;
        q_nxt.pr_lvl = q_r.pr_p2 | q_r.pr_p3;
        if (!bus_hold) begin
            q_nxt.prb_lvl = q_r.pr_p2 | q_r.pr_p3;
        end
    end

    // State register; every field clears to a constant.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Handshake terms read the registered counts directly.
    assign can_read = q_r.units >= 18'(rd_units);
    assign can_write = q_r.units <= aepr_pkg::UNITS_LIMIT;
    assign has_packet = q_r.pkts != 16'h0000;
    assign ae_flag_lvl = q_r.aef_lvl;
    assign ae_bus_lvl = q_r.aeb_lvl;
    assign pr_flag_lvl = q_r.pr_lvl;
    assign pr_bus_lvl = q_r.prb_lvl;

    // A fresh crossing above the threshold shows on the discrete flag one cycle later.
    ae_rise_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(q_r.aef_a) |=> q_r.aef_lvl) else $error("almost-empty flag rose late");
    // A read below the threshold keeps the flag one more cycle, then drops it.
    ae_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(q_r.aef_a) |=> q_r.aef_lvl ##1 (q_r.aef_lvl == $past(q_r.aef_a)))
        else $error("almost-empty flag fell at wrong cycle");
    // A new complete packet shows as ready exactly two cycles later.
    pr_ready_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(q_r.pr_p1) |-> ##2 q_r.pr_lvl) else $error("packet ready late");
    // The last packet read leaves ready standing for two cycles, gone at the third.
    pr_gone_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(q_r.pr_p1) ##1 !q_r.pr_p1 |-> ##1 q_r.pr_lvl ##1 !q_r.pr_lvl)
        else $error("packet ready cleared at wrong cycle");
    // A write alone grows the occupancy by exactly its unit count.
    occ_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_hit && !rd_hit) |=> q_r.units == $past(q_r.units) + 18'($past(wr_units)))
        else $error("occupancy did not follow a write");
    // During a read queue switch both bus bits hold their value.
    bus_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus_hold |=> $stable(q_r.aeb_lvl) && $stable(q_r.prb_lvl))
        else $error("status bus bit moved during switch");
endmodule : aepr_queue_track
`default_nettype wire

// ### verification/aepr_port_model.sv
// Write-port and read-port controller model facing the flag block.
// Assumes accepts settle before the falling edge of clk.
`timescale 1ns/1ps
`default_nettype none
module aepr_port_model (
    input wire logic clk,
    input wire logic wr_accept,
    input wire logic rd_accept,
    output logic wr_en,
    output logic rd_en,
    output logic ws,
    output logic we,
    output logic rs
);
    // Both ports idle at time zero.
    initial begin
        {wr_en, rd_en, ws, we, rs} = 5'h0;
    end
    // One word per call; a marker goes up on the edge of its own word.
    task automatic xfer(input logic rd, input logic sop, input logic eop, output logic ok);
        int n = 0;
        @(posedge clk);
        rd_en <= rd;
        wr_en <= !rd;
        {ws, we, rs} <= {sop, eop, sop};
        do begin
            @(negedge clk);
            ok = rd ? rd_accept : wr_accept;
            @(posedge clk);
            n++;
        end while (!ok && n < 40);
        // Released markers flip, so a stale level never looks like a real marker.
        {wr_en, rd_en} <= 2'b00;
        {ws, we, rs} <= ~{ws, we, rs};
    endtask : xfer
endmodule : aepr_port_model
`default_nettype wire

// ### verification/aepr_flags_tb.sv
// Self-checking bench for the almost-empty and packet-ready flag block.
// Assumes the port model beside it; APB, straps and queue selects come from here.
`timescale 1ns/1ps
`default_nettype none
module aepr_flags_tb;
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic osel = 1'b0, msel = 1'b0, pready, pslverr, wr_accept, rd_accept, wr_en, rd_en;
    logic ws, we, rs, ae_n, pr_n, ok;
    logic [2:0] wq = 3'h0, rq = 3'h0;
    logic [7:0] paddr = 8'h0, aeb_n, prb_n;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    // Width codes per trial: five share the queue, the last two are write-only.
    logic [1:0] cin [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1};
    logic [1:0] cout [7] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};
    int failures = 0, num_checks = 0, seed = 40613, n, k;
    always #2.5 clk = ~clk;
    aepr_flags dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .default_offset_select(osel), .packet_mode_select(msel), .wr_en,
        .wr_queue(wq), .write_start_of_packet_marker(ws), .write_end_of_packet_marker(we),
        .wr_accept, .rd_en, .rd_queue(rq), .read_start_of_packet_marker(rs), .rd_accept,
        .almost_empty_flag_n(ae_n), .packet_ready_flag_n(pr_n),
        .almost_empty_status_bus_n(aeb_n), .packet_ready_status_bus_n(prb_n));
    aepr_port_model port (.clk, .wr_accept, .rd_accept, .wr_en, .rd_en, .ws, .we, .rs);
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    // APB master: the request stands until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        int i = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Sample the answer at the rising edge itself, then release.
        do begin
            @(posedge clk);
            {rdy, rd, ok} = {pready, prdata, pslverr};
            i++;
        end while (!rdy && i < 40);
        if (!rdy) begin
            failures++;
            $display("Error at %0t: no APB answer", $time);
        end
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic do_reset(input logic o, input logic m);
        {reset_n, osel, msel} <= {1'b0, o, m};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : do_reset
    // Writes needed before the status-bus bit leaves almost-empty, by width pair and sharing.
    function automatic int exp_writes(logic [1:0] wi, logic [1:0] wo, logic sh, int off);
        int m;
        m = (sh && wo == 2'h0) ? off + 2 : off + 1;
        return (wi == 2'h1) ? m * 2 : (wi == 2'h2) ? m * 4 : m;
    endfunction : exp_writes
    // A hang ends the run as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    // Main sequence: word-mode thresholds first, then packet mode after a second reset.
    initial begin
        do_reset(1'b0, 1'b0);
        chk(32'({pr_n, ae_n}), 32'h2);
        apb(1'b0, aepr_pkg::ADDR_OFFSET, 32'h0);
        chk(rd, 32'h8);
        apb(1'b0, 8'h0c, 32'h0);
        chk({rd[30:0], ok}, 32'h1);
        n = 1 + int'($unsigned($random(seed)) % 4);
        apb(1'b1, aepr_pkg::ADDR_OFFSET, 32'(n));
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, aepr_pkg::ADDR_CTRL, {28'h0, cout[i], cin[i]});
            wq <= 3'(i);
            rq <= (i < 5) ? 3'(i) : 3'h7;
            k = exp_writes(cin[i], cout[i], i < 5, n);
            repeat (k - 1) port.xfer(1'b0, 1'b0, 1'b0, ok);
            repeat (3) @(posedge clk);
            #1;
            chk(32'({aeb_n[i], ae_n}), 32'h0);
            port.xfer(1'b0, 1'b0, 1'b0, ok);
            #1;
            chk(32'({aeb_n[i], ae_n}), 32'h0);
            @(posedge clk) #1;
            chk(32'({aeb_n[i], ae_n}), {30'h0, 1'b1, i < 5});
            if (i < 5) begin
                // One read drops the queue back under the boundary.
                port.xfer(1'b1, 1'b0, 1'b0, ok);
                @(posedge clk) #1;
                chk(32'({aeb_n[i], ae_n}), 32'h3);
                @(posedge clk) #1;
                chk(32'({aeb_n[i], ae_n}), 32'h0);
            end
        end
        {wq, rq} <= 6'h0;
        do_reset(1'b1, 1'b1);
        apb(1'b0, aepr_pkg::ADDR_OFFSET, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, aepr_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h30);
        port.xfer(1'b0, 1'b1, 1'b0, ok);
        port.xfer(1'b1, 1'b1, 1'b0, ok);
        chk(32'({ok, pr_n}), 32'h1);
        port.xfer(1'b0, 1'b0, 1'b1, ok);
        @(posedge clk) #1;
        chk(32'({prb_n[0], pr_n}), 32'h3);
        @(posedge clk) #1;
        chk(32'({prb_n[0], pr_n}), 32'h0);
        port.xfer(1'b1, 1'b1, 1'b0, ok);
        repeat (2) @(posedge clk);
        #1;
        chk(32'({ok, prb_n[0], pr_n}), 32'h4);
        @(posedge clk) #1;
        chk(32'({prb_n[0], pr_n}), 32'h3);
        report_and_stop();
    end
endmodule : aepr_flags_tb
`default_nettype wire
